// [test/banked_data_memory_and_status_test.sv]
// Self-checking bench for the banked data memory and status flags
`timescale 1ns/1ns
module banked_data_memory_and_status_test;
	import bdms_pkg::*;
	logic core_clk;
	logic rst_b;
	bdms_req_type req;
	bdms_evt_type evt;
	logic [13:0] pm_rdata;
	logic [7:0] sfr_rdata;
	logic busy;
	bdms_rsp_type rsp;
	logic pm_rd;
	logic [14:0] pm_addr;
	bdms_sfr_type special_function_register;
	bdms_view_type view;
	int n_fail;
	int n_checks;
	logic [7:0] rd;
	logic [14:0] pa;
	int lat;
	// ==========================================
	// Instances
	bdms_core DUT (.core_clk(core_clk), .rst_b(rst_b), .req(req), .evt(evt),
		.pm_rdata(pm_rdata), .sfr_rdata(sfr_rdata), .busy(busy), .rsp(rsp),
		.pm_rd(pm_rd), .pm_addr(pm_addr), .special_function_register(special_function_register), .view(view));
	bdms_far_model far (.core_clk(core_clk), .pm_rd(pm_rd), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata), .special_function_register(special_function_register), .sfr_rdata(sfr_rdata));
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	// ==========================================
	// Tasks
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One request; lat counts cycles from the take edge to the answer
	task automatic xfer(input logic wr, input logic dw, input logic ind, input logic sel,
		input logic [6:0] off, input bdms_op_type op, input logic [7:0] a, input logic [7:0] b);
		@(posedge core_clk);
		req <= '{1'b1, wr, dw, ind, sel, off, op, a, b};
		@(posedge core_clk);
		req.valid <= 1'b0;
		lat = 0;
		pa = 15'h0000;
		do begin
			@(negedge core_clk);
			lat++;
			if (busy === 1'b1 && pm_rd === 1'b1) pa = pm_addr;
		end while (rsp.valid !== 1'b1 && lat < 5);
		rd = rsp.rdata;
	endtask
	task automatic wr(input logic [6:0] off, input logic [7:0] v);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, off, BDMS_OP_NONE, v, 8'h00);
	endtask
	task automatic rdc(input logic [6:0] off, input logic [7:0] exp, input string nm);
		xfer(1'b0, 1'b0, 1'b0, 1'b0, off, BDMS_OP_NONE, 8'h00, 8'h00);
		check(nm, {8'h00, rd}, {8'h00, exp});
		check("direct latency", lat[15:0], 16'h0001);
	endtask
	task automatic alu(input bdms_op_type op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] ew, input logic [7:0] es);
		xfer(1'b1, 1'b1, 1'b0, 1'b0, 7'h7f, op, a, b);
		check("w", {8'h00, view.working_register_map}, {8'h00, ew});
		check("status", {8'h00, view.status}, {8'h00, es});
	endtask
	task automatic ev(input bdms_evt_type e, input logic [7:0] es);
		@(posedge core_clk);
		evt <= e;
		@(posedge core_clk);
		evt <= 4'h0;
		@(negedge core_clk);
		check("event status", {8'h00, view.status}, {8'h00, es});
	endtask
	// ==========================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		wrap_up;
	end
	// ==========================================
	// Tests
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_b = 1'b0;
		req = '0;
		evt = '0;
		repeat (12) @(posedge core_clk);
		check("reset status", {8'h00, view.status}, 16'h0018);
		check("reset busy", {14'h0, busy, rsp.valid}, 16'h0000);
		rst_b <= 1'b1;
		// Core register map, same in every bank
		for (int i = 2; i < 12; i++) begin
			if (i == 3 || i == 8 || i == 9) continue;
			wr(i[6:0], 8'h30 + i[7:0]);
			rdc(i[6:0], 8'h30 + i[7:0], "core reg");
		end
		wr(7'h09, 8'h66);
		check("working_register_map map", {8'h00, view.working_register_map}, 16'h0066);
		wr(7'h08, 8'h07);
		check("bank map", {8'h00, view.bank_selector}, 16'h0007);
		rdc(7'h0a, 8'h3a, "core reg other bank");
		// Banking of general RAM
		wr(7'h08, 8'h02);
		wr(7'h20, 8'ha5);
		wr(7'h08, 8'h03);
		wr(7'h20, 8'h5a);
		rdc(7'h20, 8'h5a, "bank3 ram");
		wr(7'h08, 8'h02);
		rdc(7'h20, 8'ha5, "bank2 ram");
		wr(7'h08, 8'h1f);
		wr(7'h6f, 8'hee);
		rdc(7'h6f, 8'h00, "unimplemented");
		// Common RAM seen from any bank
		wr(7'h08, 8'h05);
		wr(7'h7f, 8'h3c);
		wr(7'h08, 8'h00);
		rdc(7'h7f, 8'h3c, "common ram");
		// Peripheral registers carry the bank in their address
		wr(7'h08, 8'h01);
		wr(7'h0c, 8'h77);
		wr(7'h1f, 8'h99);
		rdc(7'h0c, 8'h77, "sfr low");
		rdc(7'h1f, 8'h99, "sfr high");
		wr(7'h08, 8'h02);
		rdc(7'h0c, 8'h00, "sfr other bank");
		// Indirect data access through pointer 0
		wr(7'h04, 8'h20);
		wr(7'h05, 8'h01);
		xfer(1'b0, 1'b0, 1'b1, 1'b0, 7'h00, BDMS_OP_NONE, 8'h00, 8'h00);
		check("indirect data", {8'h00, rd}, 16'h00a5);
		rdc(7'h00, 8'ha5, "port0 direct");
		// Program memory through pointer 1
		wr(7'h06, 8'h23);
		wr(7'h07, 8'h81);
		xfer(1'b1, 1'b1, 1'b1, 1'b1, 7'h00, BDMS_OP_NONE, 8'h00, 8'h00);
		check("pm w", {8'h00, view.working_register_map}, 16'h0079);
		check("pm addr", {1'b0, pa}, 16'h0123);
		check("pm latency", lat[15:0], 16'h0002);
		xfer(1'b1, 1'b0, 1'b1, 1'b1, 7'h00, BDMS_OP_NONE, 8'h11, 8'h00);
		check("pm write answer", {8'h00, rd}, 16'h0000);
		xfer(1'b0, 1'b0, 1'b1, 1'b1, 7'h00, BDMS_OP_NONE, 8'h00, 8'h00);
		check("pm after write", {8'h00, rd}, 16'h0079);
		check("pm read latency", lat[15:0], 16'h0002);
		xfer(1'b0, 1'b0, 1'b0, 1'b1, 7'h01, BDMS_OP_NONE, 8'h00, 8'h00);
		check("port1 direct pm", {8'h00, rd}, 16'h0079);
		check("port1 pm latency", lat[15:0], 16'h0002);
		// Status writes: flags protected, top bits zero
		wr(7'h03, 8'hff);
		check("status plain", {8'h00, view.status}, 16'h001f);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, 7'h03, BDMS_OP_ADD, 8'h00, 8'h00);
		check("status flag op", {8'h00, view.status}, 16'h001c);
		// Arithmetic flags, every operation
		alu(BDMS_OP_ADD, 8'h0f, 8'h01, 8'h10, 8'h1a);
		alu(BDMS_OP_ADD, 8'hff, 8'h01, 8'h00, 8'h1f);
		alu(BDMS_OP_SUB, 8'h05, 8'h03, 8'h02, 8'h1b);
		alu(BDMS_OP_SUB, 8'h03, 8'h05, 8'hfe, 8'h18);
		alu(BDMS_OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h1c);
		alu(BDMS_OP_RLF, 8'h80, 8'h00, 8'h00, 8'h1d);
		alu(BDMS_OP_RRF, 8'h02, 8'h00, 8'h81, 8'h1c);
		alu(BDMS_OP_XOR, 8'h5a, 8'h0f, 8'h55, 8'h18);
		alu(BDMS_OP_OR, 8'h00, 8'h00, 8'h00, 8'h1c);
		alu(BDMS_OP_NONE, 8'h00, 8'h00, 8'h3c, 8'h1c);
		// Device events on the reset flags
		ev(4'h4, 8'h14);
		ev(4'h2, 8'h04);
		ev(4'h8, 8'h1c);
		wr(7'h08, 8'h05);
		ev(4'h1, 8'h1c);
		check("warm bank", {8'h00, view.bank_selector}, 16'h0000);
		// Second power-on reset in mid-run clears the arithmetic flags
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("second reset status", {8'h00, view.status}, 16'h0018);
		check("second reset w", {8'h00, view.working_register_map}, 16'h0000);
		rst_b <= 1'b1;
		rdc(7'h02, 8'h00, "pcl after reset");
		wrap_up;
	end
endmodule

// [test/bdms_far_model.sv]
// Program memory and peripheral register model on the far side of the core
`timescale 1ns/1ns
// ==========================================
// Far side model
module bdms_far_model (
	input wire logic core_clk,
	input wire logic pm_rd,
	input wire logic [14:0] pm_addr,
	output logic [13:0] pm_rdata,
	input wire bdms_pkg::bdms_sfr_type special_function_register,
	output logic [7:0] sfr_rdata
);
	import bdms_pkg::*;
	logic [7:0] mem [0:4095];
	logic tog;
	initial begin
		tog = 1'b0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	// Toggling filler so a stale bus is never read as good data
	always @(posedge core_clk) begin
		tog <= ~tog;
		if (special_function_register.valid && special_function_register.wr) mem[special_function_register.addr] <= special_function_register.wdata;
	end
	// Word derived from the address, so a wrong address shows up
	assign pm_rdata = pm_rd ? {pm_addr[13:8] ^ 6'h15, pm_addr[7:0] ^ 8'h5a} : {14{tog}};
	assign sfr_rdata = special_function_register.valid ? mem[special_function_register.addr] : {8{tog}};
endmodule

// [verilog/bdms_consts.svh]
// Offsets, field positions, sizes and reset values of the banked data memory
`ifndef BDMS_CONSTS_SVH
`define BDMS_CONSTS_SVH
`define BDMS_BANKS 32
`define BDMS_BANK_BYTES 128
`define BDMS_ADDR_W 12
`define BDMS_OFF_IND0 7'h00
`define BDMS_OFF_IND1 7'h01
`define BDMS_OFF_PCL 7'h02
`define BDMS_OFF_STATUS 7'h03
`define BDMS_OFF_POINTER0_LOW 7'h04
`define BDMS_OFF_POINTER0_HIGH 7'h05
`define BDMS_OFF_POINTER1_LOW 7'h06
`define BDMS_OFF_POINTER1_HIGH 7'h07
`define BDMS_OFF_BSR 7'h08
`define BDMS_OFF_WORKING_REGISTER_MAP 7'h09
`define BDMS_OFF_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define BDMS_OFF_INTERRUPT_CONTROL 7'h0b
`define BDMS_OFF_SFR_LO 7'h0c
`define BDMS_OFF_SFR_HI 7'h1f
`define BDMS_OFF_GPR_LO 7'h20
`define BDMS_OFF_GPR_HI 7'h6f
`define BDMS_OFF_COM_LO 7'h70
`define BDMS_GPR_BYTES 80
`define BDMS_GPR_BANKS 4
`define BDMS_COM_BYTES 16
`define BDMS_PM_SEL_BIT 15
`define BDMS_ST_TO 4
`define BDMS_ST_PD 3
`define BDMS_ST_Z 2
`define BDMS_ST_DC 1
`define BDMS_ST_C 0
`define BDMS_RST_TO 1'b1
`define BDMS_RST_PD 1'b1
`define BDMS_RST_FLAG 1'b0
`define BDMS_RST_BYTE 8'h00
`endif

// [verilog/bdms_core.sv]
// Banked data memory, core registers and status flags of the CPU core
`timescale 1ns/1ns
`include "bdms_consts.svh"
module bdms_core (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire bdms_pkg::bdms_req_type req,
	input wire bdms_pkg::bdms_evt_type evt,
	input wire logic [13:0] pm_rdata,
	input wire logic [7:0] sfr_rdata,
	output logic busy,
	output bdms_pkg::bdms_rsp_type rsp,
	output logic pm_rd,
	output logic [14:0] pm_addr,
	output bdms_pkg::bdms_sfr_type special_function_register,
	output bdms_pkg::bdms_view_type view
);
	import bdms_pkg::*;

	// ==========================================
	// State and decode
	bdms_state_type st_r;
	bdms_state_type st_nxt;
	logic take;
	logic eff_ind;
	logic eff_sel;
	logic [15:0] ptr;
	logic [11:0] addr;
	logic [4:0] bank;
	logic [6:0] off;
	logic pm_hit;
	logic in_sfr;
	logic in_gpr;
	logic in_com;
	logic has_gpr;
	logic [6:0] gidx;
	logic [3:0] cidx;
	logic upd_z;
	logic upd_dc;
	logic upd_c;
	logic flag_op;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic [7:0] rdat;
	logic [7:0] status_rd;

	assign take = req.valid && (st_r.state == BDMS_ST_IDLE);
	// Direct access to offsets 0 and 1 is an indirect port access
	assign eff_ind = req.ind || (req.off[6:1] == 6'h00);
	assign eff_sel = req.ind ? req.sel : req.off[0];
	assign ptr = eff_sel ? {st_r.pointer1_high, st_r.pointer1_low} : {st_r.pointer0_high, st_r.pointer0_low};
	// Bank from pointer or from bank select
	assign addr = eff_ind ? ptr[11:0] : {st_r.bank_selector[4:0], req.off};
	assign bank = addr[11:7]; // 32 banks of 128
	assign off = addr[6:0];
	assign pm_hit = eff_ind && ptr[`BDMS_PM_SEL_BIT];
	assign in_sfr = (off >= `BDMS_OFF_SFR_LO) && (off <= `BDMS_OFF_SFR_HI);
	assign in_gpr = (off >= `BDMS_OFF_GPR_LO) && (off <= `BDMS_OFF_GPR_HI);
	assign in_com = (off >= `BDMS_OFF_COM_LO);
	// General RAM is only built in the low banks to save area
	assign has_gpr = (bank < 5'(`BDMS_GPR_BANKS));
	assign gidx = off - `BDMS_OFF_GPR_LO;
	assign cidx = off[3:0];
	assign status_rd = {3'h0, st_r.to, st_r.pd, st_r.z, st_r.dc, st_r.c};

	// ==========================================
	// Arithmetic and flag results
	assign upd_z = (req.op != BDMS_OP_NONE) && (req.op != BDMS_OP_RLF)
		&& (req.op != BDMS_OP_RRF);
	assign upd_dc = (req.op == BDMS_OP_ADD) || (req.op == BDMS_OP_SUB);
	assign upd_c = upd_dc || (req.op == BDMS_OP_RLF) || (req.op == BDMS_OP_RRF);
	assign flag_op = upd_z || upd_c;

	always_comb begin
		sum = {1'b0, req.opa};
		nib = 5'h00;
		case (req.op)
			BDMS_OP_ADD: begin
				sum = {1'b0, req.opa} + {1'b0, req.opb};
				nib = {1'b0, req.opa[3:0]} + {1'b0, req.opb[3:0]};
			end
			BDMS_OP_SUB: begin
				// Two's complement add, carry out means no borrow
				sum = {1'b0, req.opa} + {1'b0, ~req.opb} + 9'h001;
				nib = {1'b0, req.opa[3:0]} + {1'b0, ~req.opb[3:0]} + 5'h01;
			end
			BDMS_OP_AND: begin
				sum = {1'b0, req.opa & req.opb};
			end
			BDMS_OP_OR: begin
				sum = {1'b0, req.opa | req.opb};
			end
			BDMS_OP_XOR: begin
				sum = {1'b0, req.opa ^ req.opb};
			end
			BDMS_OP_RLF: begin
				sum = {req.opa, st_r.c};
			end
			BDMS_OP_RRF: begin
				sum = {req.opa[0], st_r.c, req.opa[7:1]};
			end
			default: begin
				sum = {1'b0, req.opa};
			end
		endcase
		res = sum[7:0];
	end

	// ==========================================
	// Read multiplexer
	always_comb begin
		rdat = 8'h00; // Holes read as zero
		if (in_com) begin
			rdat = st_r.com[cidx];
		end else if (in_gpr) begin
			if (has_gpr) begin
				rdat = st_r.general_purpose_ram[bank[1:0]][gidx];
			end
		end else if (in_sfr) begin
			rdat = sfr_rdata;
		end else begin
			case (off)
				`BDMS_OFF_PCL: rdat = st_r.program_counter_low;
				`BDMS_OFF_STATUS: rdat = status_rd;
				`BDMS_OFF_POINTER0_LOW: rdat = st_r.pointer0_low;
				`BDMS_OFF_POINTER0_HIGH: rdat = st_r.pointer0_high;
				`BDMS_OFF_POINTER1_LOW: rdat = st_r.pointer1_low;
				`BDMS_OFF_POINTER1_HIGH: rdat = st_r.pointer1_high;
				`BDMS_OFF_BSR: rdat = st_r.bank_selector;
				`BDMS_OFF_WORKING_REGISTER_MAP: rdat = st_r.working_register_map;
				`BDMS_OFF_PROGRAM_COUNTER_LATCH_HIGH: rdat = st_r.program_counter_latch_high;
				`BDMS_OFF_INTERRUPT_CONTROL: rdat = st_r.interrupt_control;
				default: rdat = 8'h00;
			endcase
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp_valid = 1'b0;
		case (st_r.state)
			BDMS_ST_IDLE: begin
				if (take && pm_hit && !(req.wr && !req.dest_w)) begin
					// Program word needs one more cycle
					st_nxt.state = BDMS_ST_PM_WAIT;
					st_nxt.pm_addr = ptr[14:0];
					st_nxt.pend_w = req.dest_w;
				end else if (take) begin
					st_nxt.rsp_valid = 1'b1;
					st_nxt.rsp_rdata = pm_hit ? 8'h00 : rdat;
					if (req.wr && req.dest_w) begin
						st_nxt.working_register_map = (req.op == BDMS_OP_NONE) ? rdat : res;
					end else if (req.wr && !pm_hit) begin
						if (in_com) begin
							st_nxt.com[cidx] = res;
						end else if (in_gpr && has_gpr) begin
							st_nxt.general_purpose_ram[bank[1:0]][gidx] = res;
						end else begin
							case (off)
								`BDMS_OFF_PCL: st_nxt.program_counter_low = res;
								`BDMS_OFF_STATUS: begin
									// Time-out and power-down not writable
									if (!flag_op) begin
										st_nxt.z = res[`BDMS_ST_Z];
										st_nxt.dc = res[`BDMS_ST_DC];
										st_nxt.c = res[`BDMS_ST_C];
									end
								end
								`BDMS_OFF_POINTER0_LOW: st_nxt.pointer0_low = res;
								`BDMS_OFF_POINTER0_HIGH: st_nxt.pointer0_high = res;
								`BDMS_OFF_POINTER1_LOW: st_nxt.pointer1_low = res;
								`BDMS_OFF_POINTER1_HIGH: st_nxt.pointer1_high = res;
								`BDMS_OFF_BSR: st_nxt.bank_selector = res;
								`BDMS_OFF_WORKING_REGISTER_MAP: st_nxt.working_register_map = res;
								`BDMS_OFF_PROGRAM_COUNTER_LATCH_HIGH: st_nxt.program_counter_latch_high = res;
								`BDMS_OFF_INTERRUPT_CONTROL: st_nxt.interrupt_control = res;
								default: st_nxt.program_counter_low = st_r.program_counter_low;
							endcase
						end
					end
					// Instruction logic owns the flags, after any file write
					if (!pm_hit) begin
						if (upd_z) begin
							st_nxt.z = (res == 8'h00);
						end
						if (upd_dc) begin
							st_nxt.dc = nib[4];
						end
						if (upd_c) begin
							st_nxt.c = sum[8];
						end
					end
				end
			end
			BDMS_ST_PM_WAIT: begin
				st_nxt.state = BDMS_ST_IDLE;
				st_nxt.rsp_valid = 1'b1;
				st_nxt.rsp_rdata = pm_rdata[7:0];
				if (st_r.pend_w) begin
					st_nxt.working_register_map = pm_rdata[7:0]; // Low byte only
				end
			end
			default: begin
				st_nxt.state = BDMS_ST_IDLE;
			end
		endcase
		// Device events drive the reset-status flags
		if (evt.wdt_timeout) begin
			st_nxt.to = 1'b0;
		end
		if (evt.sleep) begin
			st_nxt.to = 1'b1;
			st_nxt.pd = 1'b0;
		end
		if (evt.wdt_clear) begin
			st_nxt.to = 1'b1;
			st_nxt.pd = 1'b1;
		end
		// Other resets leave the arithmetic flags untouched
		if (evt.warm_rst) begin
			st_nxt.state = BDMS_ST_IDLE;
			st_nxt.rsp_valid = 1'b0;
			st_nxt.bank_selector = `BDMS_RST_BYTE;
			st_nxt.program_counter_latch_high = `BDMS_RST_BYTE;
			st_nxt.interrupt_control = `BDMS_RST_BYTE;
		end
	end

	// Power-on reset: time-out and power-down set, other flags clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.to <= `BDMS_RST_TO;
			st_r.pd <= `BDMS_RST_PD;
			st_r.z <= `BDMS_RST_FLAG;
			st_r.dc <= `BDMS_RST_FLAG;
			st_r.c <= `BDMS_RST_FLAG;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign busy = (st_r.state == BDMS_ST_PM_WAIT);
	assign pm_rd = busy;
	assign pm_addr = st_r.pm_addr;
	assign rsp = {st_r.rsp_valid, st_r.rsp_rdata};
	// Peripheral strobe is combinational so peripheral reads keep one cycle
	assign special_function_register = {take && !pm_hit && in_sfr, req.wr && !req.dest_w, addr, res};
	assign view = {st_r.working_register_map, status_rd, st_r.bank_selector};

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_pm_extra_cycle: assert property (
		take && pm_hit && !req.wr |-> ##1 busy ##1 rsp.valid
	) else $error("program memory read did not take two cycles");

	a_direct_one: assert property (
		take && !pm_hit |=> rsp.valid && !busy
	) else $error("direct access answer late");

	a_w_low_byte: assert property (
		take && pm_hit && req.wr && req.dest_w |-> ##2 view.working_register_map == $past(pm_rdata[7:0])
	) else $error("working register not loaded with program low byte");

	a_pm_no_write: assert property (
		take && pm_hit && req.wr && !req.dest_w |=> $stable(st_r.general_purpose_ram) && $stable(st_r.com)
	) else $error("write aimed at program memory changed data memory");

	a_unimpl_zero: assert property (
		take && !pm_hit && in_gpr && !has_gpr && !req.wr |=> rsp.rdata == 8'h00
	) else $error("unimplemented location did not read zero");

	a_status_top: assert property (
		view.status[7:5] == 3'h0
	) else $error("status high bits not zero");

	a_flags_ro: assert property (
		take && !pm_hit && req.wr && !req.dest_w && off == `BDMS_OFF_STATUS
		&& !evt.sleep && !evt.wdt_clear && !evt.wdt_timeout
		|=> $stable({st_r.to, st_r.pd})
	) else $error("software changed time-out or power-down");

	a_sleep_flags: assert property (
		evt.sleep && !evt.wdt_clear |=> !view.status[`BDMS_ST_PD] && view.status[`BDMS_ST_TO]
	) else $error("sleep flags wrong");

	a_zero_flag: assert property (
		take && !pm_hit && upd_z |=> st_r.z == ($past(res) == 8'h00)
	) else $error("zero flag wrong");

	a_carry_sub: assert property (
		take && !pm_hit && req.op == BDMS_OP_SUB |=> st_r.c == ($past(req.opa) >= $past(req.opb))
	) else $error("subtract carry is not inverted borrow");

	a_pm_addr_out: assert property (
		take && pm_hit && !req.wr |=> pm_rd && pm_addr == $past(ptr[14:0])
	) else $error("program memory address not taken from pointer");

	a_wait_one: assert property (
		busy |=> !busy
	) else $error("program memory wait longer than one cycle");

	a_zero_add: assert property (
		take && !pm_hit && req.op == BDMS_OP_ADD
		|=> st_r.z == (8'($past(req.opa) + $past(req.opb)) == 8'h00)
	) else $error("zero flag wrong after add");

	a_dcarry_add: assert property (
		take && !pm_hit && req.op == BDMS_OP_ADD
		|=> st_r.dc == (({1'b0, $past(req.opa[3:0])} + {1'b0, $past(req.opb[3:0])}) > 5'h0f)
	) else $error("digit carry wrong after add");

	a_carry_add: assert property (
		take && !pm_hit && req.op == BDMS_OP_ADD
		|=> st_r.c == (({1'b0, $past(req.opa)} + {1'b0, $past(req.opb)}) > 9'h0ff)
	) else $error("carry wrong after add");

	a_dcarry_sub: assert property (
		take && !pm_hit && req.op == BDMS_OP_SUB
		|=> st_r.dc == ($past(req.opa[3:0]) >= $past(req.opb[3:0]))
	) else $error("subtract digit carry is not inverted borrow");

	a_rotate_left: assert property (
		take && !pm_hit && req.op == BDMS_OP_RLF |=> st_r.c == $past(req.opa[7])
	) else $error("rotate left did not carry out the top bit");

	a_rotate_right: assert property (
		take && !pm_hit && req.op == BDMS_OP_RRF |=> st_r.c == $past(req.opa[0])
	) else $error("rotate right did not carry out the low bit");

	a_clear_flags: assert property (
		evt.wdt_clear |=> view.status[`BDMS_ST_TO] && view.status[`BDMS_ST_PD]
	) else $error("watchdog clear did not set time-out and power-down");

	a_timeout_flag: assert property (
		evt.wdt_timeout && !evt.sleep && !evt.wdt_clear |=> !view.status[`BDMS_ST_TO]
	) else $error("watchdog time-out did not clear the time-out flag");

	a_warm_flags: assert property (
		evt.warm_rst && !take |=> $stable({st_r.z, st_r.dc, st_r.c})
	) else $error("warm reset changed arithmetic flags");

	c_pm_read: cover property (take && pm_hit && !req.wr ##2 rsp.valid);
	c_status_flag_write: cover property (take && flag_op && off == `BDMS_OFF_STATUS && req.wr);
	c_common_ram: cover property (take && in_com && req.wr ##1 take && in_com);
	c_sub_borrow: cover property (take && req.op == BDMS_OP_SUB ##1 !st_r.c);
endmodule

// [verilog/bdms_pkg.sv]
// Types shared by the banked data memory block and its user
package bdms_pkg;
`include "bdms_consts.svh"
	typedef enum logic [2:0] {
		BDMS_OP_NONE = 3'h0,
		BDMS_OP_ADD = 3'h1,
		BDMS_OP_SUB = 3'h2,
		BDMS_OP_AND = 3'h3,
		BDMS_OP_OR = 3'h4,
		BDMS_OP_XOR = 3'h5,
		BDMS_OP_RLF = 3'h6,
		BDMS_OP_RRF = 3'h7
	} bdms_op_type;
	typedef enum logic [0:0] {
		BDMS_ST_IDLE = 1'h0,
		BDMS_ST_PM_WAIT = 1'h1
	} bdms_fsm_type;
	typedef struct packed {
		logic valid;
		logic wr;
		logic dest_w;
		logic ind;
		logic sel;
		logic [6:0] off;
		bdms_op_type op;
		logic [7:0] opa;
		logic [7:0] opb;
	} bdms_req_type;
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} bdms_rsp_type;
	typedef struct packed {
		logic valid;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} bdms_sfr_type;
	typedef struct packed {
		logic wdt_clear;
		logic sleep;
		logic wdt_timeout;
		logic warm_rst;
	} bdms_evt_type;
	typedef struct packed {
		logic [7:0] working_register_map;
		logic [7:0] status;
		logic [7:0] bank_selector;
	} bdms_view_type;
	typedef struct packed {
		bdms_fsm_type state;
		logic [14:0] pm_addr;
		logic pend_w;
		logic rsp_valid;
		logic [7:0] rsp_rdata;
		logic [7:0] program_counter_low;
		logic [7:0] pointer0_low;
		logic [7:0] pointer0_high;
		logic [7:0] pointer1_low;
		logic [7:0] pointer1_high;
		logic [7:0] bank_selector;
		logic [7:0] working_register_map;
		logic [7:0] program_counter_latch_high;
		logic [7:0] interrupt_control;
		logic to;
		logic pd;
		logic z;
		logic dc;
		logic c;
		logic [`BDMS_GPR_BANKS-1:0][`BDMS_GPR_BYTES-1:0][7:0] general_purpose_ram;
		logic [`BDMS_COM_BYTES-1:0][7:0] com;
	} bdms_state_type;
endpackage
